// ===== alrt_bank.sv
// Alert summary register and per-cell overvoltage flag register
`timescale 1ns/100ps
`default_nettype none
`include "alrt_map.svh"
// Behaviour
// - Summary bit 15 is OR of all fourteen ADC cell overvoltage flags.
// - Summary bit 14 is OR of all fourteen comparator cell overvoltage flags.
// - Summary bit 13 is OR of all fourteen ADC cell undervoltage flags.
// - Summary bit 12 is OR of all fourteen comparator cell undervoltage flags.
// - Summary bit 11 is OR of six ADC auxiliary cold flags.
// - Summary bit 10 is OR of six comparator auxiliary cold flags.
// - Summary bit 9 is OR of six ADC auxiliary hot flags.
// - Summary bit 8 is OR of six comparator auxiliary hot flags.
// - Voltage summary bits change only with their flags; writes never alter them.
// - Bit 4 marks bad ADC offset calibration; later good result clears it.
// - Bit 3 marks bad ramp offset calibration; later good result clears it.
// - Bit 2 marks bad ratiometric offset calibration; later good result clears it.
// - Bit 1 marks bad pyramid gain calibration; later good result clears it.
// - Bit 0 marks bad ramp gain calibration; later good result clears it.
// - Cell register bits 13:0 flag cells above the overvoltage threshold.
// - Polarity 0 uses unipolar threshold, polarity 1 the bipolar one.
// - A cell overvoltage flag is cleared at acquisition while its enable is 0.
// - Cell flags update only at acquisition; register is read-only.
// - Both registers reset to zero; unused bits read zero.
// - Undervoltage flags set below threshold, only when enabled, at acquisition.
module alrt_bank (
   input wire logic sys_clk,
   input wire logic rstn,
   input wire alrt_pkg::alrt_addr_t addr,
   input wire alrt_pkg::alrt_word_t wdata,
   input wire logic wr,
   input wire logic rd,
   output alrt_pkg::alrt_word_t rdata,
   input wire logic acq_done,
   input wire logic [`ALRT_CELLS-1:0][`ALRT_VOLT_W-1:0] cell_volt,
   input wire alrt_pkg::alrt_cell_vec_t polarity,
   input wire alrt_pkg::alrt_volt_t unipolar_over_threshold,
   input wire alrt_pkg::alrt_volt_t bipolar_over_threshold,
   input wire alrt_pkg::alrt_volt_t unipolar_under_threshold,
   input wire alrt_pkg::alrt_volt_t bipolar_under_threshold,
   input wire alrt_pkg::alrt_cell_vec_t cell_over_enable,
   input wire alrt_pkg::alrt_cell_vec_t cell_under_enable,
   input wire alrt_pkg::alrt_cell_vec_t cmp_cell_over_flags,
   input wire alrt_pkg::alrt_cell_vec_t cmp_cell_under_flags,
   input wire alrt_pkg::alrt_aux_vec_t aux_cold_flags,
   input wire alrt_pkg::alrt_aux_vec_t cmp_aux_cold_flags,
   input wire alrt_pkg::alrt_aux_vec_t aux_hot_flags,
   input wire alrt_pkg::alrt_aux_vec_t cmp_aux_hot_flags,
   input wire alrt_pkg::alrt_cal_vec_t cal_done,
   input wire alrt_pkg::alrt_cal_vec_t cal_bad,
   input wire alrt_pkg::alrt_cal_vec_t value_wr,
   input wire alrt_pkg::alrt_cal_vec_t value_bad,
   output alrt_pkg::alrt_word_t alert_summary,
   output alrt_pkg::alrt_cell_vec_t cell_over_flags,
   output alrt_pkg::alrt_cell_vec_t cell_under_flags
);

   alrt_pkg::alrt_word_t summary_ff;
   alrt_pkg::alrt_word_t nxt_summary;
   alrt_pkg::alrt_word_t rdata_ff;
   alrt_pkg::alrt_word_t nxt_rdata;
   alrt_pkg::alrt_cell_vec_t cell_over_ff;
   alrt_pkg::alrt_cell_vec_t nxt_cell_over;
   alrt_pkg::alrt_cell_vec_t cell_under_ff;
   alrt_pkg::alrt_cell_vec_t nxt_cell_under;
   alrt_pkg::alrt_cell_vec_t over_hit;
   alrt_pkg::alrt_cell_vec_t under_hit;
   alrt_pkg::alrt_cal_vec_t cal_fault_ff;
   alrt_pkg::alrt_cal_vec_t nxt_cal_fault;
   alrt_pkg::alrt_cal_vec_t cal_set;
   alrt_pkg::alrt_cal_vec_t cal_clr;

   // Any flag of a group raised
   function automatic logic any_cell(input alrt_pkg::alrt_cell_vec_t v);
      any_cell = |v;
   endfunction

   function automatic logic any_aux(input alrt_pkg::alrt_aux_vec_t v);
      any_aux = |v;
   endfunction

   // One comparator pair per cell
   genvar gi;
   generate
      for (gi = 0; gi < `ALRT_CELLS; gi = gi + 1) begin : g_cell
         alrt_cell_eval u_eval (
            .volt(cell_volt[gi]),
            .polarity(polarity[gi]),
            .uni_over_thr(unipolar_over_threshold),
            .bip_over_thr(bipolar_over_threshold),
            .uni_under_thr(unipolar_under_threshold),
            .bip_under_thr(bipolar_under_threshold),
            .over_en(cell_over_enable[gi]),
            .under_en(cell_under_enable[gi]),
            .over_hit(over_hit[gi]),
            .under_hit(under_hit[gi])
         );
      end
   endgenerate

   // Cell flags resample only at acquisition
   assign nxt_cell_over = acq_done ? over_hit : cell_over_ff;
   assign nxt_cell_under = acq_done ? under_hit : cell_under_ff;

   // A bad result wins over a good one in the same cycle
   assign cal_set = (cal_done & cal_bad) | (value_wr & value_bad);
   assign cal_clr = (cal_done | value_wr) & ~cal_set;
   assign nxt_cal_fault = cal_set | (cal_fault_ff & ~cal_clr);

   // Summary word built from live sources
   always_comb begin
      nxt_summary = `ALRT_WORD_RST;
      nxt_summary[`ALRT_SUM_ADC_OV] = any_cell(cell_over_ff);
      nxt_summary[`ALRT_SUM_CMP_OV] = any_cell(cmp_cell_over_flags);
      nxt_summary[`ALRT_SUM_ADC_UV] = any_cell(cell_under_ff);
      nxt_summary[`ALRT_SUM_CMP_UV] = any_cell(cmp_cell_under_flags);
      nxt_summary[`ALRT_SUM_ADC_AUX_OV] = any_aux(aux_cold_flags);
      nxt_summary[`ALRT_SUM_CMP_AUX_OV] = any_aux(cmp_aux_cold_flags);
      nxt_summary[`ALRT_SUM_ADC_AUX_UV] = any_aux(aux_hot_flags);
      nxt_summary[`ALRT_SUM_CMP_AUX_UV] = any_aux(cmp_aux_hot_flags);
      nxt_summary[`ALRT_CAL_ADC_OFS] = cal_fault_ff[`ALRT_CAL_ADC_OFS];
      nxt_summary[`ALRT_CAL_RAMP_OFS] = cal_fault_ff[`ALRT_CAL_RAMP_OFS];
      nxt_summary[`ALRT_CAL_RATIO_OFS] = cal_fault_ff[`ALRT_CAL_RATIO_OFS];
      nxt_summary[`ALRT_CAL_PYR_GAIN] = cal_fault_ff[`ALRT_CAL_PYR_GAIN];
      nxt_summary[`ALRT_CAL_RAMP_GAIN] = cal_fault_ff[`ALRT_CAL_RAMP_GAIN];
   end

   // Read decode; writes hit nothing, unmapped reads return zero
   wire logic sel_sum = addr == `ALRT_SUM_ADDR;
   wire logic sel_ovc = addr == `ALRT_OVC_ADDR;
   wire alrt_pkg::alrt_word_t ovc_word = alrt_pkg::alrt_word_t'(cell_over_ff);
   assign nxt_rdata = !rd ? `ALRT_WORD_RST :
                      sel_sum ? summary_ff :
                      sel_ovc ? ovc_word :
                      `ALRT_WORD_RST;

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         cell_over_ff <= `ALRT_CELL_RST;
         cell_under_ff <= `ALRT_CELL_RST;
         cal_fault_ff <= `ALRT_CAL_RST;
         summary_ff <= `ALRT_WORD_RST;
         rdata_ff <= `ALRT_WORD_RST;
      end else begin
         cell_over_ff <= nxt_cell_over;
         cell_under_ff <= nxt_cell_under;
         cal_fault_ff <= nxt_cal_fault;
         summary_ff <= nxt_summary;
         rdata_ff <= nxt_rdata;
      end
   end

   assign rdata = rdata_ff;
   assign alert_summary = summary_ff;
   assign cell_over_flags = cell_over_ff;
   assign cell_under_flags = cell_under_ff;

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rstn);

   a_sum_adc_ov: assert property (
      (acq_done && (over_hit != `ALRT_CELL_RST)) |=> ##1 summary_ff[`ALRT_SUM_ADC_OV])
      else $error("summary adc overvoltage bit missed a cell flag");

   a_sum_cmp_ov: assert property (
      (cmp_cell_over_flags != `ALRT_CELL_RST) |=> summary_ff[`ALRT_SUM_CMP_OV])
      else $error("summary comparator overvoltage bit missed a flag");

   a_sum_adc_uv: assert property (
      (cell_under_ff == `ALRT_CELL_RST) |=> !summary_ff[`ALRT_SUM_ADC_UV])
      else $error("summary adc undervoltage bit set with no flag");

   a_sum_cmp_uv: assert property (
      summary_ff[`ALRT_SUM_CMP_UV] == $past(any_cell(cmp_cell_under_flags)))
      else $error("summary comparator undervoltage bit wrong");

   a_sum_aux_cold: assert property (
      (aux_cold_flags != 6'h00) |=> summary_ff[`ALRT_SUM_ADC_AUX_OV])
      else $error("summary auxiliary cold bit missed a flag");

   a_sum_cmp_cold: assert property (
      (cmp_aux_cold_flags == 6'h00) |=> !summary_ff[`ALRT_SUM_CMP_AUX_OV])
      else $error("summary comparator cold bit set with no flag");

   a_sum_aux_hot: assert property (
      (aux_hot_flags != 6'h00) |=> summary_ff[`ALRT_SUM_ADC_AUX_UV])
      else $error("summary auxiliary hot bit missed a flag");

   a_sum_cmp_hot: assert property (
      (cmp_aux_hot_flags == 6'h00) |=> !summary_ff[`ALRT_SUM_CMP_AUX_UV])
      else $error("summary comparator hot bit set with no flag");

   a_sum_fall_acq: assert property (
      $fell(summary_ff[`ALRT_SUM_ADC_OV]) |-> $past(acq_done, 2))
      else $error("adc overvoltage summary cleared without acquisition");

   a_cal_adc_set: assert property (
      (cal_done[`ALRT_CAL_ADC_OFS] && cal_bad[`ALRT_CAL_ADC_OFS])
      |=> cal_fault_ff[`ALRT_CAL_ADC_OFS] ##1 summary_ff[`ALRT_CAL_ADC_OFS])
      else $error("adc offset calibration fault not flagged");

   a_cal_ramp_ofs: assert property (
      (value_wr[`ALRT_CAL_RAMP_OFS] && !value_bad[`ALRT_CAL_RAMP_OFS]
       && !(cal_done[`ALRT_CAL_RAMP_OFS] && cal_bad[`ALRT_CAL_RAMP_OFS]))
      |=> !cal_fault_ff[`ALRT_CAL_RAMP_OFS])
      else $error("ramp offset fault not cleared by good write");

   a_cal_ratio: assert property (
      (value_wr[`ALRT_CAL_RATIO_OFS] && value_bad[`ALRT_CAL_RATIO_OFS])
      |=> cal_fault_ff[`ALRT_CAL_RATIO_OFS])
      else $error("ratiometric offset fault not flagged");

   a_cal_pyr_hold: assert property (
      $fell(cal_fault_ff[`ALRT_CAL_PYR_GAIN])
      |-> $past(cal_done[`ALRT_CAL_PYR_GAIN] || value_wr[`ALRT_CAL_PYR_GAIN]))
      else $error("pyramid gain fault cleared without a result");

   a_cal_rampg_clr: assert property (
      (cal_done[`ALRT_CAL_RAMP_GAIN] && !cal_bad[`ALRT_CAL_RAMP_GAIN]
       && !value_wr[`ALRT_CAL_RAMP_GAIN])
      |=> !cal_fault_ff[`ALRT_CAL_RAMP_GAIN] ##1 !summary_ff[`ALRT_CAL_RAMP_GAIN])
      else $error("ramp gain fault not cleared by good calibration");

   a_cell_ov_set: assert property (
      (acq_done && cell_over_enable[0] && !polarity[0]
       && (cell_volt[0] > unipolar_over_threshold)) |=> cell_over_flags[0])
      else $error("cell 1 overvoltage not flagged");

   a_cell_bip_sel: assert property (
      (acq_done && cell_over_enable[0] && polarity[0]
       && ($signed(cell_volt[0]) <= $signed(bipolar_over_threshold))) |=> !cell_over_flags[0])
      else $error("cell 1 bipolar threshold not used");

   a_cell_ov_gate: assert property (
      acq_done |=> ((cell_over_ff & ~$past(cell_over_enable)) == `ALRT_CELL_RST))
      else $error("disabled cell overvoltage flag set");

   a_cell_ov_hold: assert property (
      (!acq_done && wr) |=> $stable(cell_over_ff))
      else $error("cell overvoltage flags changed without acquisition");

   a_read_gaps: assert property (
      (rd && sel_sum) |=> (rdata[`ALRT_SUM_GAP_MSB:`ALRT_SUM_GAP_LSB] == 3'h0)
                          && (rdata == $past(summary_ff)))
      else $error("summary read wrong or unused bits set");

   a_read_ovc: assert property (
      (rd && sel_ovc) |=> (rdata[`ALRT_OVC_GAP_MSB:`ALRT_OVC_GAP_LSB] == 2'h0)
                          && (rdata[`ALRT_CELLS-1:0] == $past(cell_over_ff)))
      else $error("cell register read wrong or unused bits set");

   a_cell_uv_gate: assert property (
      acq_done |=> (cell_under_ff == ($past(under_hit) & $past(cell_under_enable))))
      else $error("cell undervoltage flags wrong after acquisition");

   a_sum_lag: assert property (
      (rd && sel_sum) |=> rdata[`ALRT_SUM_CMP_OV] == $past(any_cell(cmp_cell_over_flags), 2))
      else $error("summary lags its source by more than one clock");

   a_adc_ov_clr: assert property (
      (cell_over_ff == `ALRT_CELL_RST) |=> !summary_ff[`ALRT_SUM_ADC_OV])
      else $error("summary adc overvoltage bit set with no flag");

   a_cmp_ov_clr: assert property (
      (cmp_cell_over_flags == `ALRT_CELL_RST) |=> !summary_ff[`ALRT_SUM_CMP_OV])
      else $error("summary comparator overvoltage bit set with no flag");

   a_adc_uv_set: assert property (
      (cell_under_ff != `ALRT_CELL_RST) |=> summary_ff[`ALRT_SUM_ADC_UV])
      else $error("summary adc undervoltage bit missed a flag");

   a_aux_cold_clr: assert property (
      !any_aux(aux_cold_flags) |=> !summary_ff[`ALRT_SUM_ADC_AUX_OV])
      else $error("summary auxiliary cold bit set with no flag");

   a_cmp_cold_set: assert property (
      any_aux(cmp_aux_cold_flags) |=> summary_ff[`ALRT_SUM_CMP_AUX_OV])
      else $error("summary comparator cold bit missed a flag");

   a_aux_hot_clr: assert property (
      !any_aux(aux_hot_flags) |=> !summary_ff[`ALRT_SUM_ADC_AUX_UV])
      else $error("summary auxiliary hot bit set with no flag");

   a_cmp_hot_set: assert property (
      any_aux(cmp_aux_hot_flags) |=> summary_ff[`ALRT_SUM_CMP_AUX_UV])
      else $error("summary comparator hot bit missed a flag");

   a_uv_rise_acq: assert property (
      $rose(summary_ff[`ALRT_SUM_ADC_UV]) |-> $past(acq_done, 2))
      else $error("adc undervoltage summary set without acquisition");

   a_ov_idle_hold: assert property (
      !acq_done |=> $stable(cell_over_ff))
      else $error("cell overvoltage flags moved between acquisitions");

   a_uv_idle_hold: assert property (
      !acq_done |=> $stable(cell_under_ff))
      else $error("cell undervoltage flags moved between acquisitions");

   a_cal_adc_clr: assert property (
      (cal_done[`ALRT_CAL_ADC_OFS] && !cal_bad[`ALRT_CAL_ADC_OFS]
       && !(value_wr[`ALRT_CAL_ADC_OFS] && value_bad[`ALRT_CAL_ADC_OFS]))
      |=> !cal_fault_ff[`ALRT_CAL_ADC_OFS])
      else $error("adc offset fault not cleared by good calibration");

   a_cal_ramp_set: assert property (
      (cal_done[`ALRT_CAL_RAMP_OFS] && cal_bad[`ALRT_CAL_RAMP_OFS])
      |=> cal_fault_ff[`ALRT_CAL_RAMP_OFS])
      else $error("ramp offset calibration fault not flagged");

   a_cal_ratio_clr: assert property (
      (value_wr[`ALRT_CAL_RATIO_OFS] && !value_bad[`ALRT_CAL_RATIO_OFS]
       && !(cal_done[`ALRT_CAL_RATIO_OFS] && cal_bad[`ALRT_CAL_RATIO_OFS]))
      |=> !cal_fault_ff[`ALRT_CAL_RATIO_OFS])
      else $error("ratiometric offset fault not cleared by good write");

   a_cal_pyr_set: assert property (
      (cal_done[`ALRT_CAL_PYR_GAIN] && cal_bad[`ALRT_CAL_PYR_GAIN])
      |=> cal_fault_ff[`ALRT_CAL_PYR_GAIN])
      else $error("pyramid gain calibration fault not flagged");

   a_cal_rampg_set: assert property (
      (value_wr[`ALRT_CAL_RAMP_GAIN] && value_bad[`ALRT_CAL_RAMP_GAIN])
      |=> cal_fault_ff[`ALRT_CAL_RAMP_GAIN])
      else $error("ramp gain fault not flagged on bad write");

   a_cal_quiet_hold: assert property (
      ((cal_done | value_wr) == `ALRT_CAL_RST) |=> $stable(cal_fault_ff))
      else $error("calibration fault changed without a result");

   a_cell_top_set: assert property (
      (acq_done && cell_over_enable[`ALRT_CELLS-1] && !polarity[`ALRT_CELLS-1]
       && (cell_volt[`ALRT_CELLS-1] > unipolar_over_threshold))
      |=> cell_over_flags[`ALRT_CELLS-1])
      else $error("top cell overvoltage not flagged");

   a_cell_bip_set: assert property (
      (acq_done && cell_over_enable[`ALRT_CELLS-1] && polarity[`ALRT_CELLS-1]
       && ($signed(cell_volt[`ALRT_CELLS-1]) > $signed(bipolar_over_threshold)))
      |=> cell_over_flags[`ALRT_CELLS-1])
      else $error("top cell bipolar overvoltage not flagged");

   a_cell_top_gate: assert property (
      (acq_done && !cell_over_enable[`ALRT_CELLS-1]) |=> !cell_over_flags[`ALRT_CELLS-1])
      else $error("disabled top cell overvoltage flag set");

   a_cell_uv_set: assert property (
      (acq_done && cell_under_enable[0] && !polarity[0]
       && (cell_volt[0] < unipolar_under_threshold))
      |=> cell_under_flags[0])
      else $error("cell 1 undervoltage not flagged");

   a_read_idle: assert property (
      !rd |=> rdata == `ALRT_WORD_RST)
      else $error("read data present without a read");

endmodule
`default_nettype wire

// ===== alrt_map.svh
// Register offsets, bit positions, widths and reset values of the alert bank
`ifndef ALRT_MAP_SVH
`define ALRT_MAP_SVH
`define ALRT_ADDR_W 8
`define ALRT_DATA_W 16
`define ALRT_VOLT_W 16
`define ALRT_CELLS 14
`define ALRT_AUXS 6
`define ALRT_CALS 5
`define ALRT_SUM_ADDR 8'h07
`define ALRT_OVC_ADDR 8'h08
`define ALRT_WORD_RST 16'h0000
`define ALRT_CELL_RST 14'h0000
`define ALRT_CAL_RST 5'h00
`define ALRT_SUM_ADC_OV 15
`define ALRT_SUM_CMP_OV 14
`define ALRT_SUM_ADC_UV 13
`define ALRT_SUM_CMP_UV 12
`define ALRT_SUM_ADC_AUX_OV 11
`define ALRT_SUM_CMP_AUX_OV 10
`define ALRT_SUM_ADC_AUX_UV 9
`define ALRT_SUM_CMP_AUX_UV 8
`define ALRT_SUM_GAP_MSB 7
`define ALRT_SUM_GAP_LSB 5
`define ALRT_CAL_ADC_OFS 4
`define ALRT_CAL_RAMP_OFS 3
`define ALRT_CAL_RATIO_OFS 2
`define ALRT_CAL_PYR_GAIN 1
`define ALRT_CAL_RAMP_GAIN 0
`define ALRT_OVC_GAP_MSB 15
`define ALRT_OVC_GAP_LSB 14
`endif

// ===== alrt_pkg.sv
// Types shared by the alert bank modules
`default_nettype none
`include "alrt_map.svh"
package alrt_pkg;
   typedef logic [`ALRT_ADDR_W-1:0] alrt_addr_t;
   typedef logic [`ALRT_DATA_W-1:0] alrt_word_t;
   typedef logic [`ALRT_VOLT_W-1:0] alrt_volt_t;
   typedef logic [`ALRT_CELLS-1:0] alrt_cell_vec_t;
   typedef logic [`ALRT_AUXS-1:0] alrt_aux_vec_t;
   typedef logic [`ALRT_CALS-1:0] alrt_cal_vec_t;
endpackage
`default_nettype wire

// ===== alrt_cell_eval.sv
// Threshold comparison of one cell voltage for overvoltage and undervoltage
`timescale 1ns/100ps
`default_nettype none
module alrt_cell_eval (
   input wire alrt_pkg::alrt_volt_t volt,
   input wire logic polarity,
   input wire alrt_pkg::alrt_volt_t uni_over_thr,
   input wire alrt_pkg::alrt_volt_t bip_over_thr,
   input wire alrt_pkg::alrt_volt_t uni_under_thr,
   input wire alrt_pkg::alrt_volt_t bip_under_thr,
   input wire logic over_en,
   input wire logic under_en,
   output logic over_hit,
   output logic under_hit
);
   // Unipolar codes compare unsigned, bipolar codes signed
   wire logic uni_over = volt > uni_over_thr;
   wire logic bip_over = $signed(volt) > $signed(bip_over_thr);
   wire logic uni_under = volt < uni_under_thr;
   wire logic bip_under = $signed(volt) < $signed(bip_under_thr);
   assign over_hit = over_en & (polarity ? bip_over : uni_over);
   assign under_hit = under_en & (polarity ? bip_under : uni_under);
endmodule
`default_nettype wire

// ===== tb_alrt_bank.sv
// Self-checking testbench of the alert summary and cell overvoltage register bank
`timescale 1ns/100ps
`default_nettype none
`include "alrt_map.svh"
module tb_alrt_bank;
   logic sys_clk;
   logic rstn;
   alrt_pkg::alrt_addr_t addr;
   alrt_pkg::alrt_word_t wdata;
   logic wr, rd, acq_done;
   logic [`ALRT_CELLS-1:0][`ALRT_VOLT_W-1:0] cell_volt;
   alrt_pkg::alrt_cell_vec_t polarity, cell_over_enable, cell_under_enable;
   alrt_pkg::alrt_cell_vec_t cmp_cell_over_flags, cmp_cell_under_flags;
   alrt_pkg::alrt_volt_t unipolar_over_threshold, bipolar_over_threshold;
   alrt_pkg::alrt_volt_t unipolar_under_threshold, bipolar_under_threshold;
   alrt_pkg::alrt_aux_vec_t aux_cold_flags, cmp_aux_cold_flags, aux_hot_flags, cmp_aux_hot_flags;
   alrt_pkg::alrt_cal_vec_t cal_done, cal_bad, value_wr, value_bad;
   alrt_pkg::alrt_word_t rdata, alert_summary;
   alrt_pkg::alrt_cell_vec_t cell_over_flags, cell_under_flags;
   int err_total, checks_done;
   logic [13:0] m_ov, m_uv;
   logic [4:0] m_cal;
   logic [15:0] m_sum, m_rdata;

   alrt_bank dut (.sys_clk, .rstn, .addr, .wdata, .wr, .rd, .rdata, .acq_done, .cell_volt, .polarity,
      .unipolar_over_threshold, .bipolar_over_threshold, .unipolar_under_threshold,
      .bipolar_under_threshold, .cell_over_enable, .cell_under_enable, .cmp_cell_over_flags,
      .cmp_cell_under_flags, .aux_cold_flags, .cmp_aux_cold_flags, .aux_hot_flags, .cmp_aux_hot_flags,
      .cal_done, .cal_bad, .value_wr, .value_bad, .alert_summary, .cell_over_flags, .cell_under_flags);

   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   // Reference model, updated on the same edges as the bank
   always @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         m_ov = '0;
         m_uv = '0;
         m_cal = '0;
         m_sum = 16'h0000;
         m_rdata = 16'h0000;
      end else begin
         m_rdata = !rd ? 16'h0000 : (addr == `ALRT_SUM_ADDR) ? m_sum :
            (addr == `ALRT_OVC_ADDR) ? {2'b00, m_ov} : 16'h0000;
         m_sum = {|m_ov, |cmp_cell_over_flags, |m_uv, |cmp_cell_under_flags, |aux_cold_flags,
            |cmp_aux_cold_flags, |aux_hot_flags, |cmp_aux_hot_flags, 3'b000, m_cal};
         for (int i = 0; i < 5; i++) begin
            if ((cal_done[i] && cal_bad[i]) || (value_wr[i] && value_bad[i])) begin
               m_cal[i] = 1'b1;
            end else if (cal_done[i] || value_wr[i]) begin
               m_cal[i] = 1'b0;
            end
         end
         if (acq_done) begin
            for (int n = 0; n < 14; n++) begin
               m_ov[n] = cell_over_enable[n] && (polarity[n] ?
                  $signed(cell_volt[n]) > $signed(bipolar_over_threshold) : cell_volt[n] > unipolar_over_threshold);
               m_uv[n] = cell_under_enable[n] && (polarity[n] ?
                  $signed(cell_volt[n]) < $signed(bipolar_under_threshold) : cell_volt[n] < unipolar_under_threshold);
            end
         end
      end
   end

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         err_total++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // Every result compared once per cycle where it is settled
   always @(negedge sys_clk) begin
      check(alert_summary, m_sum);
      check({2'b00, cell_over_flags}, {2'b00, m_ov});
      check({2'b00, cell_under_flags}, {2'b00, m_uv});
      check(rdata, m_rdata);
   end

   // All sources idle, as around a reset of the whole device
   task automatic quiet();
      {addr, wdata, wr, rd, acq_done, cell_volt, polarity} <= '0;
      {cell_over_enable, cell_under_enable, cmp_cell_over_flags, cmp_cell_under_flags} <= '0;
      {unipolar_over_threshold, bipolar_over_threshold, unipolar_under_threshold, bipolar_under_threshold} <= '0;
      {aux_cold_flags, cmp_aux_cold_flags, aux_hot_flags, cmp_aux_hot_flags} <= '0;
      {cal_done, cal_bad, value_wr, value_bad} <= '0;
   endtask

   function automatic logic [13:0] sparse();
      return ($urandom % 3 == 0) ? 14'h0001 << ($urandom % 14) : 14'h0000;
   endfunction

   task automatic drive_random();
      int s;
      s = $urandom % 4;
      rd <= (s == 1);
      wr <= (s == 2);
      addr <= ($urandom % 4 == 0) ? 8'($urandom) : (($urandom % 2) ? `ALRT_SUM_ADDR : `ALRT_OVC_ADDR);
      wdata <= 16'($urandom);
      acq_done <= ($urandom % 4 == 0);
      for (int n = 0; n < 14; n++) begin
         cell_volt[n] <= 16'($urandom);
      end
      polarity <= 14'($urandom);
      cell_over_enable <= ($urandom % 4 == 0) ? 14'h0000 : 14'($urandom);
      cell_under_enable <= ($urandom % 4 == 0) ? 14'h0000 : 14'($urandom);
      unipolar_over_threshold <= 16'($urandom);
      bipolar_over_threshold <= 16'($urandom);
      unipolar_under_threshold <= 16'($urandom);
      bipolar_under_threshold <= 16'($urandom);
      cmp_cell_over_flags <= sparse();
      cmp_cell_under_flags <= sparse();
      aux_cold_flags <= 6'(sparse());
      cmp_aux_cold_flags <= 6'(sparse());
      aux_hot_flags <= 6'(sparse());
      cmp_aux_hot_flags <= 6'(sparse());
      cal_done <= 5'($urandom & $urandom & $urandom);
      cal_bad <= 5'($urandom);
      value_wr <= 5'($urandom & $urandom & $urandom);
      value_bad <= 5'($urandom);
   endtask

   task automatic conclude();
      $display("checks_done=%0d err_total=%0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   initial begin
      repeat (100000) @(posedge sys_clk);
      err_total++;
      conclude();
   end

   initial begin
      err_total = 0;
      checks_done = 0;
      void'($urandom(32'h0000_18fc));
      rstn = 1'b0;
      quiet();
      repeat (2) @(posedge sys_clk);
      rstn <= 1'b1;
      // Reset values read back over the bus first
      @(posedge sys_clk);
      rd <= 1'b1;
      addr <= `ALRT_SUM_ADDR;
      @(posedge sys_clk);
      addr <= `ALRT_OVC_ADDR;
      @(posedge sys_clk);
      rd <= 1'b0;
      for (int k = 0; k < 3000; k++) begin
         @(posedge sys_clk);
         if (k == 1500) begin
            rstn <= 1'b0;
            quiet();
            repeat (2) @(posedge sys_clk);
            rstn <= 1'b1;
         end
         drive_random();
      end
      @(posedge sys_clk);
      conclude();
   end
endmodule
`default_nettype wire
